//--- logic/via_pkg.sv
/*
  Constants shared by the vectored interrupt arbiter: register offsets, field positions,
  reset values, flag and candidate indices, vector slots and priority encodings.
  Assumes a 16-bit register port with a 4-bit word address.
*/
package via_pkg;

  // ==========================================================================
  // register port
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;

  localparam logic [3:0] A_EN_LO    = 4'h0;
  localparam logic [3:0] A_EN_HI    = 4'h1;
  localparam logic [3:0] A_PRIO0    = 4'h2;
  localparam logic [3:0] A_PRIO1    = 4'h3;
  localparam logic [3:0] A_PRIO2    = 4'h4;
  localparam logic [3:0] A_PRIO4    = 4'h5;
  localparam logic [3:0] A_PRIO5    = 4'h6;
  localparam logic [3:0] A_SOFT_REQ = 4'h7;
  localparam logic [3:0] A_SOFT_EN  = 4'h8;
  localparam logic [3:0] A_FLAGS    = 4'h9;
  localparam logic [3:0] A_STATUS   = 4'hA;

  // ==========================================================================
  // field layout
  localparam int EN_GLOBAL_BIT = 7;
  localparam int EN_LO_EVENTS  = 5;
  localparam int EN_HI_EVENTS  = 4;
  localparam int LEVEL_W       = 3;
  localparam int LEVEL_LO_LSB  = 0;
  localparam int LEVEL_HI_LSB  = 4;
  localparam int STAT_REQ_BIT  = 15;
  localparam int STAT_LVL_LSB  = 8;

  localparam logic [7:0] EN_LO_RST  = 8'h00;
  localparam logic [3:0] EN_HI_RST  = 4'h0;
  localparam logic [7:0] PRIO_RST   = 8'h00;
  localparam logic [7:0] PRIO_MASK  = 8'h77;
  localparam logic [7:0] SOFT_RST   = 8'h00;
  localparam logic [7:0] SOFT_MASK  = 8'hFE;

  // ==========================================================================
  // pending flags
  localparam int NFLAG     = 17;
  localparam int F_RESET   = 0;
  localparam int F_TRAP1   = 1;
  localparam int F_SWTRAP  = 6;
  localparam int F_EVT0    = 7;
  localparam int NEVT_FLAG = 10;
  localparam int NTRAP     = 5;

  // ==========================================================================
  // arbitration candidates, listed in rank order
  localparam int NCAND    = 23;
  localparam int IDX_W    = 5;
  localparam int PRIO_W   = 5;
  localparam int C_RESET  = 0;
  localparam int C_SWTRAP = 6;
  localparam int C_EVT0   = 7;
  localparam int NEVT     = 9;
  localparam int C_TMR2   = 11;
  localparam int C_SOFT1  = 16;
  localparam int NSOFT    = 7;
  localparam int NHWCLR   = 4;

  localparam logic [4:0] EXC_PRIO      = 5'h10;
  localparam logic [4:0] EVT_PRIO_BASE = 5'h08;

  localparam logic [15:0] VEC_SWTRAP_BASE = 16'h0040;
  localparam logic [15:0] VEC_TABLE [NCAND] = '{
    16'h0000, 16'h0004, 16'h0008, 16'h000C, 16'h0010, 16'h0014, 16'h0040,
    16'h0080, 16'h0084, 16'h0088, 16'h008C, 16'h0090,
    16'h00A0, 16'h00A4, 16'h00A8, 16'h00AC,
    16'h0100, 16'h0104, 16'h0108, 16'h010C, 16'h0110, 16'h0114, 16'h0118
  };

endpackage : via_pkg

//--- logic/via_flag_bank.sv
/*
  Bank of sticky pending flags, one per bit.
  Assumes set and clear are synchronous one-cycle pulses; a set always beats a clear.
*/
`timescale 1ns/1ps
module via_flag_bank #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] set_in,
  input  wire logic [W-1:0] clr_in,
  output logic      [W-1:0] flags
);

  logic [W-1:0] next_flags;

  // ==========================================================================
  // per-bit next value
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      always_comb begin
        next_flags[g] = set_in[g] | (flags[g] & ~clr_in[g]);
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flags <= '0;
    end else begin
      flags <= next_flags;
    end
  end

endmodule : via_flag_bank

//--- logic/via_rank_select.sv
/*
  Combinational winner search over candidates held in rank order.
  Assumes index 0 is the highest rank; priority values compare unsigned.
*/
`timescale 1ns/1ps
module via_rank_select #(
  parameter int N = 8
) (
  input  wire logic [N-1:0]                req,
  input  wire logic [via_pkg::PRIO_W-1:0]  prio [N],
  output logic                             win_valid,
  output logic      [via_pkg::IDX_W-1:0]   win_idx,
  output logic      [via_pkg::PRIO_W-1:0]  win_prio
);

  // ==========================================================================
  // scan upward; only a strictly higher priority displaces the current best,
  // so ties stay with the lowest rank number
  always_comb begin
    win_valid = 1'b0;
    win_idx   = '0;
    win_prio  = '0;
    for (int i = 0; i < N; i++) begin
      if (req[i] && (!win_valid || prio[i] > win_prio)) begin
        win_valid = 1'b1;
        win_idx   = via_pkg::IDX_W'(i);
        win_prio  = prio[i];
      end
    end
  end

endmodule : via_rank_select

//--- logic/via_arbiter.sv
/*
  Vectored interrupt arbiter top: pending flags, enable and priority registers,
  arbitration among exceptions, traps, peripheral events and software interrupts,
  and a registered request/vector toward the core.
  Assumes peripheral and exception inputs are one-cycle synchronous pulses on MCLK,
  and that the core pulses IRQ_ACK for one cycle when it takes the shown request.
*/
`timescale 1ns/1ps
module via_arbiter (
  input  wire logic        MCLK,
  input  wire logic        RST_N,
  input  wire logic [3:0]  REG_ADDR,
  input  wire logic [15:0] REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output logic      [15:0] REG_RDATA,
  input  wire logic        RESET_EVENT,
  input  wire logic [4:0]  TRAP_EVENT,
  input  wire logic        SWTRAP_EVENT,
  input  wire logic [3:0]  SWTRAP_NUM,
  input  wire logic [9:0]  EVENT_IN,
  input  wire logic [3:0]  CORE_LEVEL,
  input  wire logic        IRQ_ACK,
  output logic             IRQ_REQ,
  output logic      [15:0] IRQ_VECTOR,
  output logic      [4:0]  IRQ_LEVEL,
  output logic      [4:0]  IRQ_SOURCE
);

  // ==========================================================================
  // software-visible state
  logic [7:0]  irq_enable_low_reg;
  logic [3:0]  irq_enable_high_reg;
  logic [7:0]  priority_reg_0;
  logic [7:0]  priority_reg_1;
  logic [7:0]  priority_reg_2;
  logic [7:0]  priority_reg_4;
  logic [7:0]  priority_reg_5;
  logic [7:0]  soft_request;
  logic [7:0]  soft_allow;
  logic [3:0]  swtrap_num;
  logic [7:0]  next_en_lo;
  logic [3:0]  next_en_hi;
  logic [7:0]  next_p0;
  logic [7:0]  next_p1;
  logic [7:0]  next_p2;
  logic [7:0]  next_p4;
  logic [7:0]  next_p5;
  logic [7:0]  next_soft_req;
  logic [7:0]  next_soft_en;
  logic [3:0]  next_swtrap_num;
  logic [15:0] next_rdata;

  logic [via_pkg::NFLAG-1:0] flags;
  logic [via_pkg::NFLAG-1:0] flag_set;
  logic [via_pkg::NFLAG-1:0] flag_clr;

  logic                      ext_irq0_pending;
  logic                      tmr0_overflow_flag;
  logic                      ext_irq1_pending;
  logic                      tmr1_overflow_flag;
  logic                      tmr2_overflow_flag;
  logic                      tmr2_capture_reload_flag;
  logic                      serial0_rx_flag;
  logic                      serial0_tx_flag;
  logic                      serial1_rx_flag;
  logic                      serial1_tx_flag;

  // ==========================================================================
  // arbitration nets
  logic                       global_irq_allow;
  logic [via_pkg::NEVT-1:0]   evt_flag;
  logic [via_pkg::NEVT-1:0]   evt_allow;
  logic [2:0]                 evt_level [via_pkg::NEVT];
  logic [via_pkg::NCAND-1:0]  cand_req;
  logic [4:0]                 cand_prio [via_pkg::NCAND];
  logic                       win_valid;
  logic [4:0]                 win_idx;
  logic [4:0]                 win_prio;
  logic [15:0]                win_vector;
  logic                       next_irq_req;

  // ==========================================================================
  // register writes
  always_comb begin
    next_en_lo      = irq_enable_low_reg;
    next_en_hi      = irq_enable_high_reg;
    next_p0         = priority_reg_0;
    next_p1         = priority_reg_1;
    next_p2         = priority_reg_2;
    next_p4         = priority_reg_4;
    next_p5         = priority_reg_5;
    next_soft_req   = soft_request;
    next_soft_en    = soft_allow;
    next_swtrap_num = swtrap_num;
    if (REG_WR) begin
      unique case (REG_ADDR)
        via_pkg::A_EN_LO:    next_en_lo    = REG_WDATA[7:0] & 8'h9F;
        via_pkg::A_EN_HI:    next_en_hi    = REG_WDATA[3:0];
        via_pkg::A_PRIO0:    next_p0       = REG_WDATA[7:0] & via_pkg::PRIO_MASK;
        via_pkg::A_PRIO1:    next_p1       = REG_WDATA[7:0] & via_pkg::PRIO_MASK;
        via_pkg::A_PRIO2:    next_p2       = REG_WDATA[7:0] & 8'h07;
        via_pkg::A_PRIO4:    next_p4       = REG_WDATA[7:0] & via_pkg::PRIO_MASK;
        via_pkg::A_PRIO5:    next_p5       = REG_WDATA[7:0] & via_pkg::PRIO_MASK;
        via_pkg::A_SOFT_REQ: next_soft_req = REG_WDATA[7:0] & via_pkg::SOFT_MASK;
        via_pkg::A_SOFT_EN:  next_soft_en  = REG_WDATA[7:0] & via_pkg::SOFT_MASK;
        default: ;
      endcase
    end
    // newest trap number wins if two trap instructions land before service
    if (SWTRAP_EVENT) begin
      next_swtrap_num = SWTRAP_NUM;
    end
  end

  // ==========================================================================
  // register reads, answered one cycle after the strobe
  always_comb begin
    next_rdata = 16'h0000;
    if (REG_RD) begin
      unique case (REG_ADDR)
        via_pkg::A_EN_LO:    next_rdata = {8'h00, irq_enable_low_reg};
        via_pkg::A_EN_HI:    next_rdata = {12'h000, irq_enable_high_reg};
        via_pkg::A_PRIO0:    next_rdata = {8'h00, priority_reg_0};
        via_pkg::A_PRIO1:    next_rdata = {8'h00, priority_reg_1};
        via_pkg::A_PRIO2:    next_rdata = {8'h00, priority_reg_2};
        via_pkg::A_PRIO4:    next_rdata = {8'h00, priority_reg_4};
        via_pkg::A_PRIO5:    next_rdata = {8'h00, priority_reg_5};
        via_pkg::A_SOFT_REQ: next_rdata = {8'h00, soft_request};
        via_pkg::A_SOFT_EN:  next_rdata = {8'h00, soft_allow};
        via_pkg::A_FLAGS:    next_rdata = {6'h00, flags[via_pkg::NFLAG-1:via_pkg::F_EVT0]};
        via_pkg::A_STATUS:   next_rdata = {IRQ_REQ, 2'b00, IRQ_LEVEL, 3'b000, IRQ_SOURCE};
        default:             next_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      irq_enable_low_reg  <= via_pkg::EN_LO_RST;
      irq_enable_high_reg <= via_pkg::EN_HI_RST;
      priority_reg_0      <= via_pkg::PRIO_RST;
      priority_reg_1      <= via_pkg::PRIO_RST;
      priority_reg_2      <= via_pkg::PRIO_RST;
      priority_reg_4      <= via_pkg::PRIO_RST;
      priority_reg_5      <= via_pkg::PRIO_RST;
      soft_request        <= via_pkg::SOFT_RST;
      soft_allow          <= via_pkg::SOFT_RST;
      swtrap_num          <= 4'h0;
      REG_RDATA           <= 16'h0000;
    end else begin
      irq_enable_low_reg  <= next_en_lo;
      irq_enable_high_reg <= next_en_hi;
      priority_reg_0      <= next_p0;
      priority_reg_1      <= next_p1;
      priority_reg_2      <= next_p2;
      priority_reg_4      <= next_p4;
      priority_reg_5      <= next_p5;
      soft_request        <= next_soft_req;
      soft_allow          <= next_soft_en;
      swtrap_num          <= next_swtrap_num;
      REG_RDATA           <= next_rdata;
    end
  end

  // ==========================================================================
  // pending flags: hardware sets, acknowledge or software write-one clears
  always_comb begin
    flag_set = {EVENT_IN, SWTRAP_EVENT, TRAP_EVENT, RESET_EVENT};
    flag_clr = '0;
    if (REG_WR && REG_ADDR == via_pkg::A_FLAGS) begin
      flag_clr[via_pkg::NFLAG-1:via_pkg::F_EVT0] = REG_WDATA[via_pkg::NEVT_FLAG-1:0];
    end
    // exceptions and the simple events self-clear when taken; timer 2 carries two
    // causes in one slot, and it and the serial flags are left for software to clear
    if (IRQ_ACK && IRQ_REQ && IRQ_SOURCE < 5'(via_pkg::C_TMR2)) begin
      flag_clr[IRQ_SOURCE] = 1'b1;
    end
  end

  via_flag_bank #(
    .W (via_pkg::NFLAG)
  ) u_flags (
    .clk    (MCLK),
    .rst_n  (RST_N),
    .set_in (flag_set),
    .clr_in (flag_clr),
    .flags  (flags)
  );

  // ==========================================================================
  // candidate requests and priorities, indexed in rank order
  always_comb begin
    global_irq_allow = irq_enable_low_reg[via_pkg::EN_GLOBAL_BIT];
    evt_allow = {irq_enable_high_reg, irq_enable_low_reg[via_pkg::EN_LO_EVENTS-1:0]};
    // timer 2 has two causes sharing one slot; the ack leaves both set, so
    // software clears them, and whichever is still set keeps the slot asking
    ext_irq0_pending         = flags[via_pkg::F_EVT0];
    tmr0_overflow_flag       = flags[via_pkg::F_EVT0 + 1];
    ext_irq1_pending         = flags[via_pkg::F_EVT0 + 2];
    tmr1_overflow_flag       = flags[via_pkg::F_EVT0 + 3];
    tmr2_overflow_flag       = flags[via_pkg::F_EVT0 + 4];
    tmr2_capture_reload_flag = flags[via_pkg::F_EVT0 + 5];
    serial0_rx_flag          = flags[via_pkg::F_EVT0 + 6];
    serial0_tx_flag          = flags[via_pkg::F_EVT0 + 7];
    serial1_rx_flag          = flags[via_pkg::F_EVT0 + 8];
    serial1_tx_flag          = flags[via_pkg::F_EVT0 + 9];
    evt_flag = {serial1_tx_flag, serial1_rx_flag,
                serial0_tx_flag, serial0_rx_flag,
                tmr2_overflow_flag | tmr2_capture_reload_flag,
                tmr1_overflow_flag, ext_irq1_pending,
                tmr0_overflow_flag, ext_irq0_pending};

    evt_level[0] = priority_reg_0[2:0];
    evt_level[1] = priority_reg_0[6:4];
    evt_level[2] = priority_reg_1[2:0];
    evt_level[3] = priority_reg_1[6:4];
    evt_level[4] = priority_reg_2[2:0];
    evt_level[5] = priority_reg_4[2:0];
    evt_level[6] = priority_reg_4[6:4];
    evt_level[7] = priority_reg_5[2:0];
    evt_level[8] = priority_reg_5[6:4];

    // exceptions and traps outrank every maskable source and ignore the core level
    for (int i = 0; i < via_pkg::C_EVT0; i++) begin
      cand_req[i]  = flags[i];
      cand_prio[i] = via_pkg::EXC_PRIO;
    end
    // a source asks only while its priority is strictly above the core level
    for (int e = 0; e < via_pkg::NEVT; e++) begin
      cand_prio[via_pkg::C_EVT0 + e] =
        (evt_level[e] == 3'h0) ? 5'h00 : via_pkg::EVT_PRIO_BASE + {2'b00, evt_level[e]};
      cand_req[via_pkg::C_EVT0 + e] = evt_flag[e] & evt_allow[e] & global_irq_allow
        & (evt_level[e] != 3'h0)
        & (cand_prio[via_pkg::C_EVT0 + e] > {1'b0, CORE_LEVEL});
    end
    // soft interrupts ignore the global allow; their own allow and the core level gate them
    for (int s = 0; s < via_pkg::NSOFT; s++) begin
      cand_prio[via_pkg::C_SOFT1 + s] = 5'(s + 1);
      cand_req[via_pkg::C_SOFT1 + s]  = soft_request[s + 1] & soft_allow[s + 1]
        & (cand_prio[via_pkg::C_SOFT1 + s] > {1'b0, CORE_LEVEL});
    end
  end

  via_rank_select #(
    .N (via_pkg::NCAND)
  ) u_select (
    .req       (cand_req),
    .prio      (cand_prio),
    .win_valid (win_valid),
    .win_idx   (win_idx),
    .win_prio  (win_prio)
  );

  // ==========================================================================
  // vector lookup and registered request toward the core
  always_comb begin
    if (win_idx == 5'(via_pkg::C_SWTRAP)) begin
      win_vector = via_pkg::VEC_SWTRAP_BASE + {10'h000, swtrap_num, 2'b00};
    end else begin
      win_vector = via_pkg::VEC_TABLE[win_idx];
    end
    // drop the request for one cycle after an acknowledge so a stale winner,
    // whose flag is clearing on this edge, is never offered twice
    next_irq_req = win_valid & ~IRQ_ACK;
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      IRQ_REQ    <= 1'b0;
      IRQ_VECTOR <= 16'h0000;
      IRQ_LEVEL  <= 5'h00;
      IRQ_SOURCE <= 5'h00;
    end else begin
      IRQ_REQ    <= next_irq_req;
      IRQ_VECTOR <= win_vector;
      IRQ_LEVEL  <= win_prio;
      IRQ_SOURCE <= win_idx;
    end
  end

endmodule : via_arbiter

//--- test/via_core_model.sv
/*
  Behavioural model of the processor core that takes interrupt requests.
  Assumes the arbiter's request outputs are registered on clk; acks as a one-cycle pulse.
*/
`timescale 1ns/1ps
module via_core_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        req,
  input  wire logic [15:0] vector,
  input  wire logic [4:0]  level,
  input  wire logic [4:0]  source,
  input  wire logic [3:0]  delay,
  output logic             ack
);
  // ==========================================================================
  // acceptance and log of taken requests
  logic [3:0]  held;
  logic [4:0]  last_src;
  logic [15:0] log_vec [64];
  logic [4:0]  log_src [64];
  logic [4:0]  log_lvl [64];
  int          n_taken;

  // wait restarts when the shown source changes, so a stale winner is never taken
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack <= 1'b0;
      held <= 4'h0;
      last_src <= 5'h00;
      n_taken <= 0;
    end else begin
      last_src <= source;
      ack <= 1'b0;
      if (ack) begin
        held <= 4'h0;
        if (req) begin
          log_vec[n_taken] <= vector;
          log_src[n_taken] <= source;
          log_lvl[n_taken] <= level;
          n_taken <= n_taken + 1;
        end
      end else if (req) begin
        held <= (source == last_src) ? held + 4'h1 : 4'h1;
        ack <= ((source == last_src) ? held + 4'h1 : 4'h1) >= delay;
      end else begin
        held <= 4'h0;
      end
    end
  end
endmodule : via_core_model

//--- test/via_arbiter_sva.sv
/*
  Checker for the arbiter's outputs: slots, levels and winner timing.
  Assumes one MCLK domain and RST_N asynchronous active low; attached by bind.
*/
`timescale 1ns/1ps
module via_arbiter_sva (
  input wire logic        MCLK,
  input wire logic        RST_N,
  input wire logic [3:0]  REG_ADDR,
  input wire logic [15:0] REG_WDATA,
  input wire logic        REG_WR,
  input wire logic        REG_RD,
  input wire logic [15:0] REG_RDATA,
  input wire logic        RESET_EVENT,
  input wire logic [4:0]  TRAP_EVENT,
  input wire logic        SWTRAP_EVENT,
  input wire logic [3:0]  SWTRAP_NUM,
  input wire logic [9:0]  EVENT_IN,
  input wire logic [3:0]  CORE_LEVEL,
  input wire logic        IRQ_ACK,
  input wire logic        IRQ_REQ,
  input wire logic [15:0] IRQ_VECTOR,
  input wire logic [4:0]  IRQ_LEVEL,
  input wire logic [4:0]  IRQ_SOURCE
);
  // ==========================================================================
  // helper state
  logic [3:0]  sw_num;
  logic [3:0]  next_sw_num;
  logic [15:0] ev_vec;

  always_comb begin
    next_sw_num = SWTRAP_EVENT ? SWTRAP_NUM : sw_num;
    ev_vec = (IRQ_SOURCE < 5'h0C) ? 16'h0080 + {9'h000, IRQ_SOURCE - 5'h07, 2'h0}
                                  : 16'h00A0 + {9'h000, IRQ_SOURCE - 5'h0C, 2'h0};
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      sw_num <= 4'h0;
    end else begin
      sw_num <= next_sw_num;
    end
  end

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);

  // ==========================================================================
  // assertions
  a_reset_slot: assert property (
    IRQ_REQ && IRQ_SOURCE == 5'h00 |-> IRQ_VECTOR == 16'h0000 && IRQ_LEVEL == 5'h10)
    else $error("reset slot or level wrong");
  a_reset_wins: assert property (
    RESET_EVENT ##1 !IRQ_ACK |=> IRQ_REQ && IRQ_SOURCE == 5'h00)
    else $error("reset request not offered first");
  a_trap_first: assert property (
    (|TRAP_EVENT) ##1 !IRQ_ACK |=> IRQ_REQ && IRQ_SOURCE <= 5'h05 && IRQ_LEVEL == 5'h10)
    else $error("hardware trap not offered in time");
  a_trap_slot: assert property (
    IRQ_REQ && IRQ_SOURCE inside {[5'h01:5'h05]}
      |-> IRQ_VECTOR == {9'h000, IRQ_SOURCE, 2'h0} && IRQ_LEVEL == 5'h10)
    else $error("hardware trap slot wrong");
  a_swtrap_slot: assert property (
    IRQ_REQ && IRQ_SOURCE == 5'h06 |-> IRQ_VECTOR == {10'h001, sw_num, 2'h0})
    else $error("trap instruction slot wrong");
  a_event_slot: assert property (
    IRQ_REQ && IRQ_SOURCE inside {[5'h07:5'h0F]} |-> IRQ_VECTOR == ev_vec)
    else $error("event slot wrong");
  a_event_level: assert property (
    IRQ_REQ && IRQ_SOURCE inside {[5'h07:5'h0F]} |-> IRQ_LEVEL inside {[5'h09:5'h0F]})
    else $error("event level out of range");
  a_soft_slot: assert property (
    IRQ_REQ && IRQ_SOURCE >= 5'h10 |-> IRQ_LEVEL == IRQ_SOURCE - 5'h0F
      && IRQ_VECTOR == 16'h0100 + {9'h000, IRQ_SOURCE - 5'h10, 2'h0})
    else $error("software interrupt slot or level wrong");
endmodule : via_arbiter_sva

bind via_arbiter via_arbiter_sva via_arbiter_sva_i (
  .MCLK(MCLK), .RST_N(RST_N), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
  .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .RESET_EVENT(RESET_EVENT),
  .TRAP_EVENT(TRAP_EVENT), .SWTRAP_EVENT(SWTRAP_EVENT), .SWTRAP_NUM(SWTRAP_NUM),
  .EVENT_IN(EVENT_IN), .CORE_LEVEL(CORE_LEVEL), .IRQ_ACK(IRQ_ACK), .IRQ_REQ(IRQ_REQ),
  .IRQ_VECTOR(IRQ_VECTOR), .IRQ_LEVEL(IRQ_LEVEL), .IRQ_SOURCE(IRQ_SOURCE)
);

//--- test/via_tb.sv
/*
  Self-checking bench for via_arbiter: register port tasks, event pulses, core model.
  Assumes the package is compiled first and the checker is bound to the arbiter.
*/
`timescale 1ns/1ps
module tb;
  logic        MCLK = 1'b0;
  logic        RST_N = 1'b0;
  logic [3:0]  REG_ADDR = 4'h0;
  logic [15:0] REG_WDATA = 16'h0000;
  logic        REG_WR = 1'b0;
  logic        REG_RD = 1'b0;
  logic        RESET_EVENT = 1'b0;
  logic [4:0]  TRAP_EVENT = 5'h00;
  logic        SWTRAP_EVENT = 1'b0;
  logic [3:0]  SWTRAP_NUM = 4'h0;
  logic [9:0]  EVENT_IN = 10'h000;
  logic [3:0]  CORE_LEVEL = 4'h0;
  logic [3:0]  delay = 4'h1;
  logic [15:0] REG_RDATA, IRQ_VECTOR;
  logic [4:0]  IRQ_LEVEL, IRQ_SOURCE;
  logic        IRQ_ACK, IRQ_REQ;
  logic [7:0]  soft_req = 8'hFE;
  int          n_mismatch = 0;
  int          n_checks = 0;
  int          n_seen = 0;
  logic [3:0]  m_addr [6] = '{via_pkg::A_EN_LO, via_pkg::A_EN_HI, via_pkg::A_PRIO0,
                               via_pkg::A_PRIO2, via_pkg::A_SOFT_EN, 4'hB};
  logic [15:0] m_exp [6] = '{16'h009F, 16'h000F, 16'h0077, 16'h0007, 16'h00FE, 16'h0000};

  always #50 MCLK = ~MCLK;

  via_arbiter via_arbiter_i (
    .MCLK(MCLK), .RST_N(RST_N), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .RESET_EVENT(RESET_EVENT),
    .TRAP_EVENT(TRAP_EVENT), .SWTRAP_EVENT(SWTRAP_EVENT), .SWTRAP_NUM(SWTRAP_NUM),
    .EVENT_IN(EVENT_IN), .CORE_LEVEL(CORE_LEVEL), .IRQ_ACK(IRQ_ACK), .IRQ_REQ(IRQ_REQ),
    .IRQ_VECTOR(IRQ_VECTOR), .IRQ_LEVEL(IRQ_LEVEL), .IRQ_SOURCE(IRQ_SOURCE)
  );
  via_core_model via_core_model_i (
    .clk(MCLK), .rst_n(RST_N), .req(IRQ_REQ), .vector(IRQ_VECTOR), .level(IRQ_LEVEL),
    .source(IRQ_SOURCE), .delay(delay), .ack(IRQ_ACK)
  );

  // ==========================================================================
  // tasks
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : test_done

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // each access starts on its own edge so strobes never get two values in one step
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge MCLK);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WR <= 1'b1;
    @(posedge MCLK);
    REG_WR <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge MCLK);
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    @(posedge MCLK);
    REG_RD <= 1'b0;
    @(negedge MCLK);
    chk("read data", exp, REG_RDATA);
  endtask : rd

  task automatic fire(input logic [9:0] ev, input logic rst, input logic [4:0] trap,
                      input logic sw, input logic [3:0] num);
    @(posedge MCLK);
    EVENT_IN <= ev;
    RESET_EVENT <= rst;
    TRAP_EVENT <= trap;
    SWTRAP_EVENT <= sw;
    SWTRAP_NUM <= num;
    @(posedge MCLK);
    EVENT_IN <= 10'h000;
    RESET_EVENT <= 1'b0;
    TRAP_EVENT <= 5'h00;
    SWTRAP_EVENT <= 1'b0;
  endtask : fire

  // flags that the ack leaves set are cleared at once, as software would
  task automatic take(input logic [4:0] src, input logic [15:0] vec, input logic [4:0] lvl);
    for (int i = 0; i < 300 && via_core_model_i.n_taken <= n_seen; i++) @(posedge MCLK);
    if (via_core_model_i.n_taken <= n_seen) begin
      n_mismatch++;
      $display("wrong value taken count expected %0d seen %0d", n_seen + 1, n_seen);
      test_done();
    end
    chk("source", {11'h000, src}, {11'h000, via_core_model_i.log_src[n_seen]});
    chk("vector", vec, via_core_model_i.log_vec[n_seen]);
    chk("level", {11'h000, lvl}, {11'h000, via_core_model_i.log_lvl[n_seen]});
    n_seen++;
    if (src == 5'h0B) wr(via_pkg::A_FLAGS, 16'h0030);
    else if (src >= 5'h0C && src <= 5'h0F) wr(via_pkg::A_FLAGS, 16'h0001 << (src - 5'h06));
    else if (src >= 5'h10) begin
      soft_req[src - 5'h0F] = 1'b0;
      wr(via_pkg::A_SOFT_REQ, {8'h00, soft_req});
    end
  endtask : take

  task automatic idle();
    repeat (12) @(posedge MCLK);
    @(negedge MCLK);
    chk("request", 16'h0000, {15'h0000, IRQ_REQ});
  endtask : idle

  // ==========================================================================
  // main sequence
  initial begin
    repeat (16) @(posedge MCLK);
    RST_N <= 1'b1;
    for (int a = 0; a < 16; a++) rd(a[3:0], 16'h0000);
    for (int k = 0; k < 6; k++) begin
      wr(m_addr[k], 16'hFFFF);
      rd(m_addr[k], m_exp[k]);
    end
    fire(10'h000, 1'b1, 5'h1F, 1'b1, 4'h9);
    take(5'h00, 16'h0000, 5'h10);
    for (int k = 1; k < 6; k++) take(k[4:0], {9'h000, k[4:0], 2'h0}, 5'h10);
    take(5'h06, 16'h0064, 5'h10);
    for (int n = 0; n < 16; n++) begin
      fire(10'h000, 1'b0, 5'h00, 1'b1, n[3:0]);
      take(5'h06, 16'h0040 + {10'h000, n[3:0], 2'h0}, 5'h10);
    end
    delay <= 4'h5;
    for (int r = 2; r < 7; r++) wr(r[3:0], 16'h0011);
    fire(10'h3FF, 1'b0, 5'h00, 1'b0, 4'h0);
    for (int s = 7; s < 16; s++) begin
      take(s[4:0], (s < 12) ? 16'h0080 + 16'(4 * (s - 7)) : 16'h00A0 + 16'(4 * (s - 12)),
           5'h09);
    end
    idle();
    wr(via_pkg::A_PRIO0, 16'h0001);
    wr(via_pkg::A_PRIO1, 16'h0070);
    fire(10'h00F, 1'b0, 5'h00, 1'b0, 4'h0);
    take(5'h0A, 16'h008C, 5'h0F);
    take(5'h07, 16'h0080, 5'h09);
    idle();
    wr(via_pkg::A_EN_LO, 16'h001F);
    wr(via_pkg::A_PRIO0, 16'h0031);
    idle();
    wr(via_pkg::A_EN_LO, 16'h009B);
    take(5'h08, 16'h0084, 5'h0B);
    wr(via_pkg::A_PRIO1, 16'h0072);
    idle();
    wr(via_pkg::A_EN_LO, 16'h009F);
    take(5'h09, 16'h0088, 5'h0A);
    wr(via_pkg::A_EN_LO, 16'h001F);
    wr(via_pkg::A_SOFT_REQ, 16'h00FE);
    for (int s = 22; s > 15; s--) begin
      take(s[4:0], 16'h0100 + 16'(4 * (s - 16)), 5'(s - 15));
    end
    idle();
    // core level equal to the source priority holds it back until the level drops
    @(posedge MCLK);
    CORE_LEVEL <= 4'h9;
    wr(via_pkg::A_EN_LO, 16'h009F);
    fire(10'h001, 1'b0, 5'h00, 1'b0, 4'h0);
    idle();
    @(posedge MCLK);
    CORE_LEVEL <= 4'h0;
    take(5'h07, 16'h0080, 5'h09);
    test_done();
  end
endmodule : tb
